// file: mscg_clk_src.sv
`timescale 1ns/10ps
`default_nettype none
module mscg_clk_src (
	input  wire logic run,
	output var  logic clock_input_pin
);
	// steady 8 MHz; no spread, so no false halt
	initial clock_input_pin = 1'b1;
	always begin
		#62.5;
		clock_input_pin = run ? ~clock_input_pin : 1'b1;
	end
endmodule
`default_nettype wire

// file: mscg_halt_det.sv
`timescale 1ns/10ps
`default_nettype none
module mscg_halt_det
	import mscg_pkg::*;
#(
	parameter int WINDOW_CYCLES = MSCG_HALT_CYCLES
) (
	input  wire logic clk_sys,
	input  wire logic srst,
	input  wire logic clock_input_pin,
	output var  logic halted
);
	logic                          sync1_q;
	logic                          sync2_q;
	logic                          prev_q;
	logic [MSCG_HALT_CNT_BITS-1:0] cnt_q;
	logic [MSCG_HALT_CNT_BITS-1:0] cnt_d;
	logic                          halt_q;
	logic                          halt_d;
	wire                           edge_seen;
	wire                           expired;

	localparam logic [MSCG_HALT_CNT_BITS-1:0] LAST =
		MSCG_HALT_CNT_BITS'(WINDOW_CYCLES - 1);

	// edge seen on the synchronised copy only
	assign edge_seen = sync2_q ^ prev_q;
	assign expired   = (cnt_q == LAST);
	assign cnt_d     = edge_seen ? '0 : (expired ? cnt_q : cnt_q + 1'b1);
	// flag on a silent window, off as soon as edges return
	assign halt_d    = edge_seen ? 1'b0 : (expired ? 1'b1 : halt_q);
	assign halted    = halt_q;

	always_ff @(posedge clk_sys) begin
		sync1_q <= clock_input_pin;
		sync2_q <= sync1_q;
		if (srst) begin
			// a stopped clock idles high, so no false edge after reset
			prev_q <= 1'b1;
			cnt_q  <= '0;
			halt_q <= 1'b0;
		end else begin
			prev_q <= sync2_q;
			cnt_q  <= cnt_d;
			halt_q <= halt_d;
		end
	end
endmodule
`default_nettype wire

// file: mscg_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module mscg_monitor
	import mscg_pkg::*;
(
	input wire logic          clk_sys,
	input wire logic          srst,
	input wire logic          mode_pin_0,
	input wire logic          mode_pin_1,
	input wire logic          clock_mode_pin_lo,
	input wire logic          clock_mode_pin_hi,
	input wire logic          flash_write_protect_pin,
	input wire logic          standby,
	input var  mscg_mode_e    op_mode,
	input wire mscg_bus_cfg_s bus_cfg,
	input wire logic [1:0]    pll_mult,
	input wire logic [12:0]   periph_clk,
	input wire logic [5:0]    timer_pin_oe,
	input wire logic          osc_halted,
	input wire logic          op_undefined
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	a_decode_ext0: assert property (flash_write_protect_pin
		&& {mode_pin_1, mode_pin_0} == 2'h0 |=> op_mode == MSCG_MODE_EXT0)
		else $error("mode 0 not decoded");
	a_mode0_cfg: assert property (op_mode == MSCG_MODE_EXT0 |->
		!bus_cfg.rom_active && bus_cfg.cs0_width == MSCG_WIDTH_16)
		else $error("mode 0 bus setup wrong");
	a_mode1_cfg: assert property (op_mode == MSCG_MODE_EXT1 |->
		!bus_cfg.rom_active && bus_cfg.cs0_width == MSCG_WIDTH_32)
		else $error("mode 1 bus setup wrong");
	a_mode2_rom: assert property (op_mode == MSCG_MODE_IROM2 |->
		bus_cfg.rom_active && bus_cfg.cs0_from_bcr)
		else $error("mode 2 rom setup wrong");
	a_single_nobus: assert property (op_mode == MSCG_MODE_SINGLE3 |->
		bus_cfg.ports_general && !bus_cfg.ext_bus_enable)
		else $error("single chip mode uses bus");
	a_pll_times_two: assert property (flash_write_protect_pin
		&& {clock_mode_pin_hi, clock_mode_pin_lo} == 2'h1
		|=> pll_mult == MSCG_PLL_X2)
		else $error("pll not times two");
	a_prescale_half: assert property (!periph_clk[0] |=> periph_clk[0])
		else $error("half rate clock stuck");
	a_standby_float: assert property (standby |=> timer_pin_oe == 6'h00)
		else $error("timer pins driven in standby");
	a_halt_float: assert property (osc_halted |=> timer_pin_oe == 6'h00)
		else $error("timer pins driven while halted");
	a_undef_sticky: assert property (op_undefined |=> op_undefined)
		else $error("undefined flag dropped");
	a_undef_cause: assert property ($rose(op_undefined) |->
		$past(osc_halted) && !$past(standby))
		else $error("undefined flag without halt");
endmodule
bind mscg_top mscg_monitor u_mon (.*);
`default_nettype wire

// file: mscg_pkg.sv
package mscg_pkg;

	typedef enum {
		MSCG_MODE_EXT0,
		MSCG_MODE_EXT1,
		MSCG_MODE_IROM2,
		MSCG_MODE_SINGLE3,
		MSCG_MODE_ROM_PROG,
		MSCG_MODE_BOOT,
		MSCG_MODE_USER_PROG,
		MSCG_MODE_FLASH_PROG,
		MSCG_MODE_UNUSED
	} mscg_mode_e;

	typedef struct packed {
		logic       rom_active;
		logic       cs0_external;
		logic [1:0] cs0_width;
		logic       cs0_from_bcr;
		logic       ports_general;
		logic       ext_bus_enable;
		logic       mode_valid;
	} mscg_bus_cfg_s;

	localparam logic [1:0] MSCG_WIDTH_8  = 2'h0;
	localparam logic [1:0] MSCG_WIDTH_16 = 2'h1;
	localparam logic [1:0] MSCG_WIDTH_32 = 2'h2;

	localparam logic [1:0] MSCG_PLL_X1  = 2'h0;
	localparam logic [1:0] MSCG_PLL_X2  = 2'h1;
	localparam logic [1:0] MSCG_PLL_X4  = 2'h2;
	localparam logic [1:0] MSCG_PLL_RSV = 2'h3;

	localparam int MSCG_PRESCALE_BITS = 13;
	localparam logic [MSCG_PRESCALE_BITS-1:0] MSCG_PRESCALE_RST = 13'h0000;

	localparam int MSCG_TIMER_PINS = 6;

	localparam int MSCG_CLK_MHZ        = 125;
	localparam int MSCG_HALT_WINDOW_NS = 1000;
	localparam int MSCG_HALT_CYCLES    =
		(MSCG_HALT_WINDOW_NS * MSCG_CLK_MHZ) / 1000;
	localparam int MSCG_HALT_CNT_BITS  = 8;

endpackage

// file: mscg_top.sv
// Contract
// - protect plus two low mode pins decode the operating mode.
// - protect high, all pins one gives ROM programming; 1101 gives flash programmer.
// - mode 0 disables ROM; first area external, 8 or 16 bit.
// - mode 1 disables ROM; first area external, 16 or 32 bit.
// - mode 2 enables 32-bit ROM; external width from bus control register.
// - single-chip mode frees all ports and blocks external address accesses.
// - high mode pins pick PLL times one, two, four; 11 only programming.
// - high mode pins act as clock selectors only in modes 0 to 3.
// - prescaler divides system clock into half down to 1/8192 clocks.
// - no clock input edges forces six timer pins to high impedance.
// - standby also floats the six pins; normal again after standby ends.
// - halt outside standby leaves chip undefined until reset.
`timescale 1ns/10ps
`default_nettype none
module mscg_top
	import mscg_pkg::*;
#(
	parameter int HALT_WINDOW_CYCLES = MSCG_HALT_CYCLES,
	parameter bit LARGE_PACKAGE      = 1'b1,
	parameter bit FLASH_VARIANT      = 1'b1
) (
	input  wire  logic                          clk_sys,
	input  wire  logic                          srst,
	input  wire  logic                          mode_pin_0,
	input  wire  logic                          mode_pin_1,
	input  wire  logic                          clock_mode_pin_lo,
	input  wire  logic                          clock_mode_pin_hi,
	input  wire  logic                          flash_write_protect_pin,
	input  wire  logic                          clock_input_pin,
	input  wire  logic                          standby,
	input  wire  logic [MSCG_TIMER_PINS-1:0]    timer_pin_out_func,
	input  wire  logic [MSCG_TIMER_PINS-1:0]    timer_pin_oe_func,
	output var   mscg_mode_e                    op_mode,
	output var   mscg_bus_cfg_s                 bus_cfg,
	output var   logic [1:0]                    pll_mult,
	output var   logic                          pll_mult_valid,
	output var   logic [MSCG_PRESCALE_BITS-1:0] periph_clk_en,
	output var   logic [MSCG_PRESCALE_BITS-1:0] periph_clk,
	output var   logic [MSCG_TIMER_PINS-1:0]    timer_pin_out,
	output var   logic [MSCG_TIMER_PINS-1:0]    timer_pin_oe,
	output var   logic                          osc_halted,
	output var   logic                          op_undefined
);
	logic                          [3:0] pins;
	mscg_mode_e                    mode_d;
	mscg_mode_e                    mode_q;
	mscg_bus_cfg_s                 cfg_d;
	mscg_bus_cfg_s                 cfg_q;
	logic [1:0]                    mult_q;
	logic                          mult_ok_q;
	logic [MSCG_PRESCALE_BITS-1:0] pre_q;
	logic [MSCG_PRESCALE_BITS-1:0] pre_en_q;
	logic [MSCG_TIMER_PINS-1:0]    tout_q;
	logic [MSCG_TIMER_PINS-1:0]    toe_q;
	logic                          undef_q;
	logic                          halt_raw;
	wire                           halt_live;
	wire                           force_hiz;
	wire                           clk_sel_ok;
	wire  [1:0]                    mult_d;
	wire                           mult_ok_d;
	wire  [MSCG_PRESCALE_BITS-1:0] pre_next;
	wire  [MSCG_PRESCALE_BITS-1:0] tick;
	wire  [1:0]                    w_small;
	wire  [1:0]                    w_large;

	assign pins = {clock_mode_pin_hi, clock_mode_pin_lo, mode_pin_1,
		mode_pin_0};

	// straps are static on the board, so decode is resampled each cycle
	always_comb begin
		mode_d = MSCG_MODE_UNUSED;
		if (flash_write_protect_pin) begin
			if (pins == 4'hF)
				mode_d = MSCG_MODE_ROM_PROG;
			else if (pins == 4'hD && FLASH_VARIANT)
				mode_d = MSCG_MODE_FLASH_PROG;
			else begin
				case (pins[1:0])
				2'h0:    mode_d = MSCG_MODE_EXT0;
				2'h1:    mode_d = MSCG_MODE_EXT1;
				2'h2:    mode_d = MSCG_MODE_IROM2;
				2'h3:    mode_d = MSCG_MODE_SINGLE3;
				default: mode_d = MSCG_MODE_UNUSED;
				endcase
			end
		end else begin
			case (pins[1:0])
			2'h0:    mode_d = MSCG_MODE_BOOT;
			2'h2:    mode_d = MSCG_MODE_USER_PROG;
			default: mode_d = MSCG_MODE_UNUSED;
			endcase
		end
	end

	assign w_small = LARGE_PACKAGE ? MSCG_WIDTH_16 : MSCG_WIDTH_8;
	assign w_large = LARGE_PACKAGE ? MSCG_WIDTH_32 : MSCG_WIDTH_16;

	always_comb begin
		cfg_d = '0;
		cfg_d.mode_valid = 1'b1;
		case (mode_d)
		MSCG_MODE_EXT0: begin
			cfg_d.cs0_external   = 1'b1;
			cfg_d.cs0_width      = w_small;
			cfg_d.ext_bus_enable = 1'b1;
		end
		MSCG_MODE_EXT1: begin
			cfg_d.cs0_external   = 1'b1;
			cfg_d.cs0_width      = w_large;
			cfg_d.ext_bus_enable = 1'b1;
		end
		MSCG_MODE_IROM2, MSCG_MODE_BOOT, MSCG_MODE_USER_PROG: begin
			// rom width is 32; external width left to bus control reg two
			cfg_d.rom_active     = 1'b1;
			cfg_d.cs0_external   = 1'b1;
			cfg_d.cs0_width      = MSCG_WIDTH_32;
			cfg_d.cs0_from_bcr   = 1'b1;
			cfg_d.ext_bus_enable = 1'b1;
		end
		MSCG_MODE_SINGLE3: begin
			cfg_d.rom_active    = 1'b1;
			cfg_d.ports_general = 1'b1;
		end
		MSCG_MODE_ROM_PROG, MSCG_MODE_FLASH_PROG: begin
			cfg_d.rom_active = 1'b1;
		end
		default: cfg_d.mode_valid = 1'b0;
		endcase
	end

	// clock pins only matter in modes 0..3
	assign clk_sel_ok = (mode_d == MSCG_MODE_EXT0) ||
		(mode_d == MSCG_MODE_EXT1) || (mode_d == MSCG_MODE_IROM2) ||
		(mode_d == MSCG_MODE_SINGLE3);
	assign mult_d = clk_sel_ok ? pins[3:2] : MSCG_PLL_X1;
	assign mult_ok_d = (clk_sel_ok && pins[3:2] != MSCG_PLL_RSV) ||
		(mode_d == MSCG_MODE_ROM_PROG) || (!clk_sel_ok &&
		mode_d != MSCG_MODE_UNUSED);

	// ripple-free prescaler: bit k toggles at clk_sys/2^(k+1)
	assign pre_next = pre_q + 1'b1;
	genvar gi;
	generate
		for (gi = 0; gi < MSCG_PRESCALE_BITS; gi++) begin : g_tick
			if (gi == 0) begin : g_b0
				assign tick[gi] = 1'b1;
			end else begin : g_bn
				assign tick[gi] = &pre_q[gi-1:0];
			end
		end
	endgenerate

	mscg_halt_det #(
		.WINDOW_CYCLES (HALT_WINDOW_CYCLES)
	) u_halt (
		.clk_sys         (clk_sys),
		.srst            (srst),
		.clock_input_pin (clock_input_pin),
		.halted          (halt_raw)
	);

	// clock expected stopped in standby, so detector is ignored there
	assign halt_live = halt_raw && !standby;
	// latched undefined state only leaves on reset, trading recovery for safety
	assign force_hiz = halt_live || standby || undef_q;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mode_q    <= MSCG_MODE_UNUSED;
			cfg_q     <= '0;
			mult_q    <= MSCG_PLL_X1;
			mult_ok_q <= 1'b0;
			pre_q     <= MSCG_PRESCALE_RST;
			pre_en_q  <= '0;
			tout_q    <= '0;
			toe_q     <= '0;
			undef_q   <= 1'b0;
		end else begin
			mode_q    <= mode_d;
			cfg_q     <= cfg_d;
			mult_q    <= mult_d;
			mult_ok_q <= mult_ok_d;
			pre_q     <= pre_next;
			pre_en_q  <= tick;
			tout_q    <= force_hiz ? '0 : timer_pin_out_func;
			toe_q     <= force_hiz ? '0 : timer_pin_oe_func;
			undef_q   <= undef_q || halt_live;
		end
	end

	assign op_mode        = mode_q;
	assign bus_cfg        = cfg_q;
	assign pll_mult       = mult_q;
	assign pll_mult_valid = mult_ok_q;
	assign periph_clk     = pre_q;
	assign periph_clk_en  = pre_en_q;
	assign timer_pin_out  = tout_q;
	assign timer_pin_oe   = toe_q;
	assign osc_halted     = halt_raw;
	assign op_undefined   = undef_q;
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
	import mscg_pkg::*;
;
	logic          clk_sys = 1'b0;
	logic          srst = 1'b1;
	logic [4:0]    pins = 5'h10;
	logic          standby = 1'b0;
	logic          run = 1'b1;
	logic          osc;
	mscg_mode_e    op_mode;
	mscg_mode_e    m;
	mscg_bus_cfg_s bus_cfg;
	logic [1:0]    pll_mult;
	logic [1:0]    pe;
	logic          pv;
	logic [12:0]   pen;
	logic [5:0]    tfo = 6'h2A;
	logic [5:0]    tfe = 6'h3F;
	logic [12:0]   pclk;
	logic [5:0]    oe;
	logic [5:0]    out;
	logic          halted;
	logic          undef;
	int            n;
	int            err_count = 0;
	int            check_count = 0;
	always #4 clk_sys = ~clk_sys;
	mscg_clk_src u_src (.run(run), .clock_input_pin(osc));
	mscg_top #(.HALT_WINDOW_CYCLES(16)) u_dut (
		.clk_sys(clk_sys), .srst(srst),
		.mode_pin_0(pins[0]), .mode_pin_1(pins[1]),
		.clock_mode_pin_lo(pins[2]), .clock_mode_pin_hi(pins[3]),
		.flash_write_protect_pin(pins[4]), .clock_input_pin(osc),
		.standby(standby), .timer_pin_out_func(tfo),
		.timer_pin_oe_func(tfe), .op_mode(op_mode), .bus_cfg(bus_cfg),
		.pll_mult(pll_mult), .pll_mult_valid(pv), .periph_clk_en(pen),
		.periph_clk(pclk), .timer_pin_out(out), .timer_pin_oe(oe),
		.osc_halted(halted), .op_undefined(undef));
	task automatic cyc(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s exp %0h got %0h", nm, e, g);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// straps only move while reset holds the chip
	task automatic set_pins(input logic [4:0] p);
		srst = 1'b1;
		pins = p;
		cyc(2);
		srst = 1'b0;
		cyc(3);
	endtask
	function automatic mscg_mode_e em(input logic [4:0] p);
		if (p == 5'h1F) return MSCG_MODE_ROM_PROG;
		if (p == 5'h1D) return MSCG_MODE_FLASH_PROG;
		case ({p[4], p[1:0]})
			3'h4: return MSCG_MODE_EXT0;
			3'h5: return MSCG_MODE_EXT1;
			3'h6: return MSCG_MODE_IROM2;
			3'h7: return MSCG_MODE_SINGLE3;
			3'h0: return MSCG_MODE_BOOT;
			3'h2: return MSCG_MODE_USER_PROG;
			default: return MSCG_MODE_UNUSED;
		endcase
	endfunction
	initial begin
		cyc(2);
		srst = 1'b0;
		for (int i = 0; i < 32; i++) begin
			m = em(i[4:0]);
			set_pins(i[4:0]);
			chk("op_mode", 16'(m), 16'(op_mode));
			chk("valid", 16'(m != MSCG_MODE_UNUSED),
				16'(bus_cfg.mode_valid));
			if (m != MSCG_MODE_UNUSED)
				chk("rom", 16'(!(m inside {MSCG_MODE_EXT0, MSCG_MODE_EXT1})),
					16'(bus_cfg.rom_active));
			pe = (!i[4] || m inside {MSCG_MODE_ROM_PROG,
				MSCG_MODE_FLASH_PROG}) ? MSCG_PLL_X1 : i[3:2];
			chk("pll", 16'(pe), 16'(pll_mult));
			chk("pll_ok", 16'(m != MSCG_MODE_UNUSED && pe != MSCG_PLL_RSV),
				16'(pv));
		end
		$display("mode decode done");
		set_pins(5'h10);
		for (int k = 0; k < 13; k++) begin
			n = 0;
			while (pclk[k] !== 1'b1 && n < 20000) begin
				cyc(1);
				n++;
			end
			n = 0;
			while (pclk[k] === 1'b1 && n < 20000) begin
				cyc(1);
				n++;
			end
			chk("periph_clk", 16'(1 << k), 16'(n));
			n = 0;
			while (pen[k] !== 1'b1 && n < 20000) begin
				cyc(1);
				n++;
			end
			cyc(1);
			n = 1;
			while (pen[k] !== 1'b1 && n < 20000) begin
				cyc(1);
				n++;
			end
			chk("periph_clk_en", 16'(1 << k), 16'(n));
		end
		$display("prescaler done");
		cyc(40);
		chk("oe", 16'h003F, 16'(oe));
		chk("out", 16'h002A, 16'(out));
		tfo = 6'h15;
		cyc(2);
		chk("out", 16'h0015, 16'(out));
		standby = 1'b1;
		run = 1'b0;
		cyc(2);
		chk("oe", 16'h0000, 16'(oe));
		cyc(40);
		run = 1'b1;
		cyc(40);
		standby = 1'b0;
		cyc(2);
		chk("oe", 16'h003F, 16'(oe));
		chk("undef", 16'h0000, 16'(undef));
		run = 1'b0;
		cyc(40);
		chk("halted", 16'h0001, 16'(halted));
		chk("oe", 16'h0000, 16'(oe));
		chk("out", 16'h0000, 16'(out));
		run = 1'b1;
		cyc(40);
		chk("halted", 16'h0000, 16'(halted));
		chk("undef", 16'h0001, 16'(undef));
		chk("oe", 16'h0000, 16'(oe));
		set_pins(5'h10);
		chk("undef", 16'h0000, 16'(undef));
		$display("timer pin tests done");
		end_sim();
	end
endmodule
`default_nettype wire
